// *** core/timer_capture_pkg.sv ***
// constants of the dual timer and capture unit
// How it works
// - two independent 8-bit up-counting timers, each with period register and flag.
// - timers count the internal clock, or falling edges of the shared pin.
// - control bit 3 joins both 8-bit timers into one 16-bit timer.
// - the lower timer's period tick, and the upper timer's unless joined, give the pwm time-base.
// - third timer is 16 bits, read as high and low byte.
// - one 16-bit pair is third timer period or first capture result.
// - a separate 16-bit pair holds only second capture results.
// - both captures sample the third timer count.
// - software picks internal clock or external pin for the third timer.
// - control bits 7-6 pick the second capture event: fall, rise, 4th, 16th.
// - control bits 5-4 pick the first capture event with same encodings.
// - all control fields read and write, and reset to zero.
// - control bit 2 set counts third timer on falling pin edges.
// - control bits 1 and 0 pick pin falling edge per 8-bit timer.
// - on period match a separate 8-bit timer clears and latches its sticky flag.
package timer_capture_pkg;

  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_PERIOD_LOW  = 6'h10;
  localparam logic [5:0] IDX_PERIOD_HIGH = 6'h11;
  localparam logic [5:0] IDX_TIMER_LOW   = 6'h12;
  localparam logic [5:0] IDX_TIMER_HIGH  = 6'h13;
  localparam logic [5:0] IDX_WIDE_LOW    = 6'h14;
  localparam logic [5:0] IDX_WIDE_HIGH   = 6'h15;
  localparam logic [5:0] IDX_CONTROL     = 6'h16;
  localparam logic [5:0] IDX_PC1_LOW     = 6'h17;
  localparam logic [5:0] IDX_PC1_HIGH    = 6'h18;
  localparam logic [5:0] IDX_CAP2_LOW    = 6'h19;
  localparam logic [5:0] IDX_CAP2_HIGH   = 6'h1A;
  localparam logic [5:0] IDX_STATUS      = 6'h1B;
  localparam logic [5:0] IDX_MASK        = 6'h1C;
  localparam logic [5:0] IDX_CONFIG      = 6'h1D;

  // control field positions
  localparam int CTRL_CAP2_SEL_LSB = 6;
  localparam int CTRL_CAP1_SEL_LSB = 4;
  localparam int CTRL_PAIR_JOIN    = 3;
  localparam int CTRL_WIDE_CS      = 2;
  localparam int CTRL_UPPER_CS     = 1;
  localparam int CTRL_LOWER_CS     = 0;

  // config: 1 = pair is period of third timer, 0 = first capture result
  localparam int CFG_PERIOD_MODE = 0;

  // status and mask bit positions
  localparam int ST_LOWER = 0;
  localparam int ST_UPPER = 1;
  localparam int ST_WIDE  = 2;
  localparam int ST_CAP1  = 3;
  localparam int ST_CAP2  = 4;
  localparam int ST_WIDTH = 5;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [4:0] MASK_RESET = 5'h00;

  // capture event encodings
  localparam logic [1:0] EV_FALL    = 2'b00;
  localparam logic [1:0] EV_RISE    = 2'b01;
  localparam logic [1:0] EV_RISE_4  = 2'b10;
  localparam logic [1:0] EV_RISE_16 = 2'b11;

  // prescale counts: rising edges per event minus one
  localparam logic [3:0] PRESCALE_4_LAST  = 4'h3;
  localparam logic [3:0] PRESCALE_16_LAST = 4'hF;

endpackage

// *** core/capture_edge_detect.sv ***
// capture event detector with edge select and rising-edge prescale
`timescale 1ns/100ps
module capture_edge_detect (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  // capture pin and mode
  input  wire logic       pin_i,
  input  wire logic [1:0] mode_i,
  // one-cycle capture event
  output logic            event_o
);

  typedef struct packed {
    logic       prev;
    logic [3:0] count;
  } det_t;

  det_t s;
  det_t next_s;
  logic rise;
  logic fall;

  always_comb begin
    rise   = pin_i & ~s.prev;
    fall   = s.prev & ~pin_i;
    next_s = s;
    next_s.prev = pin_i;
    if (rise) begin
      next_s.count = s.count + 4'h1;
    end
    case (mode_i)
      timer_capture_pkg::EV_FALL:   event_o = fall;
      timer_capture_pkg::EV_RISE:   event_o = rise;
      timer_capture_pkg::EV_RISE_4: begin
        event_o = rise & (s.count[1:0] == timer_capture_pkg::PRESCALE_4_LAST[1:0]);
      end
      default: event_o = rise & (s.count == timer_capture_pkg::PRESCALE_16_LAST);
    endcase
    if (!rst_n_i) begin
      next_s = '0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    s <= next_s;
  end

endmodule

// *** core/dual_timer_capture_unit.sv ***
// dual 8-bit timers, 16-bit timer and two captures behind classic wishbone
`timescale 1ns/100ps
module dual_timer_capture_unit (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // external pins
  input  wire logic        pair_count_pin_i,
  input  wire logic        wide_count_pin_i,
  input  wire logic        cap1_pin_i,
  input  wire logic        cap2_pin_i,
  // pwm time-base
  output logic             lower_period_tick_o,
  output logic             upper_period_tick_o,
  output logic [7:0]       lower_timer_o,
  output logic [7:0]       upper_timer_o,
  // interrupt
  output logic             irq_o
);

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [7:0]  timer_capture_control;
    logic [7:0]  config_reg;
    logic [7:0]  period_low_timer;
    logic [7:0]  period_high_timer;
    logic [7:0]  lower_timer;
    logic [7:0]  upper_timer;
    logic [15:0] wide_timer;
    logic [15:0] period_or_cap1;
    logic [15:0] cap2;
    logic [4:0]  status;
    logic [4:0]  mask;
    logic        pair_pin_q;
    logic        wide_pin_q;
    logic        lower_tick;
    logic        upper_tick;
  } state_t;

  state_t s;
  state_t next_s;

  logic [4:0]  ev_set;
  logic [4:0]  ev_clr;
  logic [31:0] rd_val;
  logic [5:0]  idx;
  logic        req_new;
  logic        req_done;
  logic        wr_en;
  logic [7:0]  wbyte;
  logic        pair_fall;
  logic        wide_fall;
  logic        inc_lower;
  logic        inc_upper;
  logic        inc_wide;
  logic        period_mode;
  logic        joined;
  logic        cap1_evt;
  logic        cap2_evt;
  logic [15:0] pair_count;
  logic        lower_match;
  logic        upper_match;
  logic        join_match;
  logic        wide_match;
  logic        wide_wrap;
  logic [4:0]  pend;

  capture_edge_detect u_cap1 (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (cap1_pin_i),
    .mode_i    (s.timer_capture_control[timer_capture_pkg::CTRL_CAP1_SEL_LSB +: 2]),
    .event_o   (cap1_evt)
  );

  capture_edge_detect u_cap2 (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (cap2_pin_i),
    .mode_i    (s.timer_capture_control[timer_capture_pkg::CTRL_CAP2_SEL_LSB +: 2]),
    .event_o   (cap2_evt)
  );

  always_comb begin
    next_s = s;
    ev_set = '0;
    ev_clr = '0;
    rd_val = '0;
    idx    = adr_i[7:2];
    wbyte  = dat_i[7:0];

    // bus phases: request seen, then completed at the ack edge
    req_new  = cyc_i & stb_i & ~s.ack;
    req_done = cyc_i & stb_i & s.ack;
    wr_en    = req_done & we_i & sel_i[0];
    next_s.ack = req_new;

    // clock source selection
    pair_fall = s.pair_pin_q & ~pair_count_pin_i;
    wide_fall = s.wide_pin_q & ~wide_count_pin_i;
    next_s.pair_pin_q = pair_count_pin_i;
    next_s.wide_pin_q = wide_count_pin_i;
    if (s.timer_capture_control[timer_capture_pkg::CTRL_LOWER_CS]) begin
      inc_lower = pair_fall;
    end else begin
      inc_lower = 1'b1;
    end
    if (s.timer_capture_control[timer_capture_pkg::CTRL_UPPER_CS]) begin
      inc_upper = pair_fall;
    end else begin
      inc_upper = 1'b1;
    end
    if (s.timer_capture_control[timer_capture_pkg::CTRL_WIDE_CS]) begin
      inc_wide = wide_fall;
    end else begin
      inc_wide = 1'b1;
    end
    joined      = s.timer_capture_control[timer_capture_pkg::CTRL_PAIR_JOIN];
    period_mode = s.config_reg[timer_capture_pkg::CFG_PERIOD_MODE];
    pair_count  = {s.upper_timer, s.lower_timer};

    // period compares, taken before any count moves
    lower_match = (s.lower_timer == s.period_low_timer);
    upper_match = (s.upper_timer == s.period_high_timer);
    join_match  = (pair_count == {s.period_high_timer, s.period_low_timer});
    wide_match  = period_mode && (s.wide_timer == s.period_or_cap1);
    wide_wrap   = (s.wide_timer == 16'hFFFF);

    next_s.lower_tick = 1'b0;
    next_s.upper_tick = 1'b0;

    // 8-bit timers, separate or joined
    if (joined) begin
      if (inc_lower) begin
        if (join_match) begin
          next_s.lower_timer = '0;
          next_s.upper_timer = '0;
          next_s.lower_tick  = 1'b1;
          ev_set[timer_capture_pkg::ST_LOWER] = 1'b1;
        end else begin
          {next_s.upper_timer, next_s.lower_timer} = pair_count + 16'h0001;
        end
      end
    end else begin
      if (inc_lower) begin
        if (lower_match) begin
          next_s.lower_timer = '0;
          next_s.lower_tick  = 1'b1;
          ev_set[timer_capture_pkg::ST_LOWER] = 1'b1;
        end else begin
          next_s.lower_timer = s.lower_timer + 8'h01;
        end
      end
      if (inc_upper) begin
        if (upper_match) begin
          next_s.upper_timer = '0;
          next_s.upper_tick  = 1'b1;
          ev_set[timer_capture_pkg::ST_UPPER] = 1'b1;
        end else begin
          next_s.upper_timer = s.upper_timer + 8'h01;
        end
      end
    end

    // 16-bit third timer
    if (inc_wide) begin
      if (wide_match) begin
        next_s.wide_timer = '0;
        ev_set[timer_capture_pkg::ST_WIDE] = 1'b1;
      end else begin
        next_s.wide_timer = s.wide_timer + 16'h0001;
        if (wide_wrap) begin
          ev_set[timer_capture_pkg::ST_WIDE] = 1'b1;
        end
      end
    end

    // captures from the third timer
    if (cap1_evt && !period_mode) begin
      next_s.period_or_cap1 = s.wide_timer;
      ev_set[timer_capture_pkg::ST_CAP1] = 1'b1;
    end
    if (cap2_evt) begin
      next_s.cap2 = s.wide_timer;
      ev_set[timer_capture_pkg::ST_CAP2] = 1'b1;
    end

    // read mux
    if (idx == timer_capture_pkg::IDX_PERIOD_LOW) begin
      rd_val = {24'h00_0000, s.period_low_timer};
    end else if (idx == timer_capture_pkg::IDX_PERIOD_HIGH) begin
      rd_val = {24'h00_0000, s.period_high_timer};
    end else if (idx == timer_capture_pkg::IDX_TIMER_LOW) begin
      rd_val = {24'h00_0000, s.lower_timer};
    end else if (idx == timer_capture_pkg::IDX_TIMER_HIGH) begin
      rd_val = {24'h00_0000, s.upper_timer};
    end else if (idx == timer_capture_pkg::IDX_WIDE_LOW) begin
      rd_val = {24'h00_0000, s.wide_timer[7:0]};
    end else if (idx == timer_capture_pkg::IDX_WIDE_HIGH) begin
      rd_val = {24'h00_0000, s.wide_timer[15:8]};
    end else if (idx == timer_capture_pkg::IDX_CONTROL) begin
      rd_val = {24'h00_0000, s.timer_capture_control};
    end else if (idx == timer_capture_pkg::IDX_PC1_LOW) begin
      rd_val = {24'h00_0000, s.period_or_cap1[7:0]};
    end else if (idx == timer_capture_pkg::IDX_PC1_HIGH) begin
      rd_val = {24'h00_0000, s.period_or_cap1[15:8]};
    end else if (idx == timer_capture_pkg::IDX_CAP2_LOW) begin
      rd_val = {24'h00_0000, s.cap2[7:0]};
    end else if (idx == timer_capture_pkg::IDX_CAP2_HIGH) begin
      rd_val = {24'h00_0000, s.cap2[15:8]};
    end else if (idx == timer_capture_pkg::IDX_STATUS) begin
      rd_val = {27'h000_0000, s.status};
    end else if (idx == timer_capture_pkg::IDX_MASK) begin
      rd_val = {27'h000_0000, s.mask};
    end else if (idx == timer_capture_pkg::IDX_CONFIG) begin
      rd_val = {31'h0000_0000, s.config_reg[timer_capture_pkg::CFG_PERIOD_MODE]};
    end else begin
      rd_val = '0;
    end
    if (req_new && !we_i) begin
      next_s.rdata = rd_val;
    end

    // status read clears at the ack edge
    if (req_done && !we_i && (idx == timer_capture_pkg::IDX_STATUS)) begin
      ev_clr = '1;
    end

    // writes take effect at the ack edge and win over counting
    if (wr_en) begin
      if (idx == timer_capture_pkg::IDX_PERIOD_LOW) begin
        next_s.period_low_timer = wbyte;
      end else if (idx == timer_capture_pkg::IDX_PERIOD_HIGH) begin
        next_s.period_high_timer = wbyte;
      end else if (idx == timer_capture_pkg::IDX_TIMER_LOW) begin
        next_s.lower_timer = wbyte;
      end else if (idx == timer_capture_pkg::IDX_TIMER_HIGH) begin
        next_s.upper_timer = wbyte;
      end else if (idx == timer_capture_pkg::IDX_WIDE_LOW) begin
        next_s.wide_timer[7:0] = wbyte;
      end else if (idx == timer_capture_pkg::IDX_WIDE_HIGH) begin
        next_s.wide_timer[15:8] = wbyte;
      end else if (idx == timer_capture_pkg::IDX_CONTROL) begin
        next_s.timer_capture_control = wbyte;
      end else if (idx == timer_capture_pkg::IDX_PC1_LOW) begin
        next_s.period_or_cap1[7:0] = wbyte;
      end else if (idx == timer_capture_pkg::IDX_PC1_HIGH) begin
        next_s.period_or_cap1[15:8] = wbyte;
      end else if (idx == timer_capture_pkg::IDX_MASK) begin
        next_s.mask = wbyte[4:0];
      end else if (idx == timer_capture_pkg::IDX_CONFIG) begin
        next_s.config_reg = {7'h00, wbyte[timer_capture_pkg::CFG_PERIOD_MODE]};
      end
    end

    // set wins over clear
    next_s.status = (s.status & ~ev_clr) | ev_set;

    if (!rst_n_i) begin
      next_s = '0;
      next_s.timer_capture_control = timer_capture_pkg::CTRL_RESET;
      next_s.config_reg            = timer_capture_pkg::CFG_RESET;
      next_s.mask                  = timer_capture_pkg::MASK_RESET;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    s <= next_s;
  end

  assign dat_o               = s.rdata;
  assign ack_o               = s.ack;
  assign lower_period_tick_o = s.lower_tick;
  assign upper_period_tick_o = s.upper_tick;
  assign lower_timer_o       = s.lower_timer;
  assign upper_timer_o       = s.upper_timer;

  // one pending bit per status flag
  for (genvar b = 0; b < timer_capture_pkg::ST_WIDTH; b++) begin : g_pend
    assign pend[b] = s.status[b] & s.mask[b];
  end

  assign irq_o = |pend;

endmodule

// *** dv/timer_capture_checker.sv ***
// port assertions of the dual timer and capture unit
`timescale 1ns/100ps
module timer_capture_checker (
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  // bus
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // time-base
  input wire logic        lower_period_tick_o,
  input wire logic        upper_period_tick_o,
  input wire logic [7:0]  lower_timer_o,
  input wire logic [7:0]  upper_timer_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_ack_next_cycle: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  chk_ack_one_pulse: assert property (
    ack_o |=> !ack_o) else $error("ack too long");
  chk_ack_has_cause: assert property (
    ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
  chk_read_byte_wide: assert property (
    ack_o && !we_i |-> dat_o[31:8] == 24'h00_0000) else $error("read upper bits set");
  chk_read_data_holds: assert property (
    !$past(cyc_i && stb_i && !we_i && !ack_o) |-> $stable(dat_o)) else $error("dat_o moved");
  chk_lower_tick_clear: assert property (
    lower_period_tick_o && !$past(ack_o && we_i) |-> lower_timer_o == 8'h00)
    else $error("lower tick without clear");
  chk_upper_tick_clear: assert property (
    upper_period_tick_o && !$past(ack_o && we_i) |-> upper_timer_o == 8'h00)
    else $error("upper tick without clear");
  chk_lower_step_one: assert property (
    !$past(ack_o && we_i) && lower_timer_o != $past(lower_timer_o)
    |-> lower_timer_o == $past(lower_timer_o) + 8'h01 || lower_timer_o == 8'h00)
    else $error("lower timer jumped");
  chk_upper_step_one: assert property (
    !$past(ack_o && we_i) && upper_timer_o != $past(upper_timer_o)
    |-> upper_timer_o == $past(upper_timer_o) + 8'h01 || upper_timer_o == 8'h00)
    else $error("upper timer jumped");
endmodule

// *** dv/pin_partner.sv ***
// behavioural source of the count and capture pins
`timescale 1ns/100ps
module pin_partner (
  // clock
  input  wire logic       ref_clk_i,
  // pulse request, one bit a pin
  input  wire logic [3:0] go_i,
  // pins and status
  output logic [3:0]      pins_o = 4'h0,
  output logic            busy_o
);
  logic [2:0] cnt = 3'h0;
  assign busy_o = (cnt != 3'h0);
  // two cycles high then three low: one rise and one fall a pulse
  always @(posedge ref_clk_i) begin
    if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
      if (cnt == 3'h4) begin
        pins_o <= 4'h0;
      end
    end else if (go_i != 4'h0) begin
      cnt    <= 3'h5;
      pins_o <= go_i;
    end
  end
endmodule

// *** dv/testbench.sv ***
// self-checking bench of the dual timer and capture unit
`timescale 1ns/100ps
module testbench;
  typedef struct {logic [5:0] idx; logic [7:0] wr; logic [7:0] rd;} row_t;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr  = 8'h00;
  logic [3:0]  sel  = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, q;
  logic        ack, ltick, utick, irq, busy;
  logic [7:0]  ltmr, utmr;
  logic [3:0]  go = 4'h0;
  logic [3:0]  pins;
  logic [15:0] wide = 16'h1200;
  int          n_errors = 0, checks_done = 0, cycles = 0, gap, rises = 0;
  row_t        rows [10] = '{
    '{timer_capture_pkg::IDX_CONTROL, 8'hFF, 8'hFF}, '{timer_capture_pkg::IDX_PERIOD_LOW, 8'h5A, 8'h5A},
    '{timer_capture_pkg::IDX_PERIOD_HIGH, 8'h3C, 8'h3C}, '{timer_capture_pkg::IDX_CAP2_LOW, 8'h77, 8'h00},
    '{timer_capture_pkg::IDX_CAP2_HIGH, 8'h77, 8'h00}, '{timer_capture_pkg::IDX_MASK, 8'h1F, 8'h1F},
    '{timer_capture_pkg::IDX_CONFIG, 8'h01, 8'h01}, '{timer_capture_pkg::IDX_CONFIG, 8'h00, 8'h00},
    '{timer_capture_pkg::IDX_CONTROL, 8'h00, 8'h00}, '{6'h3F, 8'h11, 8'h00}};

  dual_timer_capture_unit uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .pair_count_pin_i(pins[0]), .wide_count_pin_i(pins[1]), .cap1_pin_i(pins[2]),
    .cap2_pin_i(pins[3]), .lower_period_tick_o(ltick), .upper_period_tick_o(utick),
    .lower_timer_o(ltmr), .upper_timer_o(utmr), .irq_o(irq));
  pin_partner partner (.ref_clk_i(ref_clk_i), .go_i(go), .pins_o(pins), .busy_o(busy));

  always #20 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_gap(input string what, input int exp, input int got);
    checks_done++;
    if (got != exp) begin
      n_errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // single classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    sel  <= 4'hF;
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge ref_clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic pulse(input logic [3:0] m);
    go <= m;
    @(posedge ref_clk_i);
    go <= 4'h0;
    @(posedge ref_clk_i);
    while (busy === 1'b1) @(posedge ref_clk_i);
  endtask
  // edges from one tick to the next
  task automatic measure(input logic up, output int n);
    n = 0;
    while ((up ? utick : ltick) !== 1'b1 && n < 2000) begin
      @(posedge ref_clk_i);
      n++;
    end
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while ((up ? utick : ltick) !== 1'b1 && n < 2000);
  endtask

  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    wb(1'b0, timer_capture_pkg::IDX_CONTROL, 8'h00);
    chk_val("control reset", 32'h0000_0000, q);
    foreach (rows[i]) begin
      wb(1'b1, rows[i].idx, rows[i].wr);
      wb(1'b0, rows[i].idx, 8'h00);
      chk_val("readback", {24'h00_0000, rows[i].rd}, q);
    end
    wb(1'b1, timer_capture_pkg::IDX_PERIOD_LOW, 8'h09);
    wb(1'b1, timer_capture_pkg::IDX_PERIOD_HIGH, 8'h04);
    measure(1'b0, gap);
    chk_gap("lower period", 10, gap);
    measure(1'b1, gap);
    chk_gap("upper period", 5, gap);
    wb(1'b1, timer_capture_pkg::IDX_MASK, 8'h00);
    chk_val("irq masked", 32'h0000_0000, {31'h0, irq});
    wb(1'b0, timer_capture_pkg::IDX_STATUS, 8'h00);
    chk_val("timer flags", 32'h0000_0003, q & 32'h0000_0003);
    wb(1'b1, timer_capture_pkg::IDX_MASK, 8'h01);
    repeat (12) @(posedge ref_clk_i);
    chk_val("irq unmasked", 32'h0000_0001, {31'h0, irq});
    wb(1'b1, timer_capture_pkg::IDX_PERIOD_LOW, 8'h03);
    wb(1'b1, timer_capture_pkg::IDX_PERIOD_HIGH, 8'h01);
    wb(1'b1, timer_capture_pkg::IDX_CONTROL, 8'h08);
    wb(1'b1, timer_capture_pkg::IDX_TIMER_HIGH, 8'h00);
    wb(1'b1, timer_capture_pkg::IDX_TIMER_LOW, 8'h00);
    measure(1'b0, gap);
    chk_gap("joined period", 260, gap);
    wb(1'b1, timer_capture_pkg::IDX_CONTROL, 8'h01);
    wb(1'b1, timer_capture_pkg::IDX_PERIOD_LOW, 8'hFF);
    wb(1'b1, timer_capture_pkg::IDX_TIMER_LOW, 8'h00);
    repeat (5) pulse(4'h1);
    chk_val("pin count", 32'h0000_0005, {24'h00_0000, ltmr});
    wb(1'b1, timer_capture_pkg::IDX_CONTROL, 8'h04);
    wb(1'b1, timer_capture_pkg::IDX_WIDE_LOW, 8'h00);
    wb(1'b1, timer_capture_pkg::IDX_WIDE_HIGH, 8'h12);
    // prescaled modes see the running rise count, so pad to a multiple first
    for (int m = 0; m < 4; m++) begin
      int k;
      k = (m < 2) ? 1 : ((m == 2) ? 4 : 16);
      wb(1'b1, timer_capture_pkg::IDX_CONTROL, {m[1:0], m[1:0], 4'h4});
      while (rises % k != 0) begin
        pulse(4'hC);
        rises++;
      end
      pulse(4'h2);
      wide++;
      repeat (k - 1) pulse(4'hC);
      rises += k;
      wb(1'b0, timer_capture_pkg::IDX_CAP2_LOW, 8'h00);
      chk_val("cap2 before event", {24'h00_0000, wide[7:0] - 8'h01}, q);
      pulse(4'hC);
      wb(1'b0, timer_capture_pkg::IDX_WIDE_LOW, 8'h00);
      chk_val("wide pin count", {24'h00_0000, wide[7:0]}, q);
      wb(1'b0, timer_capture_pkg::IDX_CAP2_LOW, 8'h00);
      chk_val("cap2 low", {24'h00_0000, wide[7:0]}, q);
      wb(1'b0, timer_capture_pkg::IDX_CAP2_HIGH, 8'h00);
      chk_val("cap2 high", 32'h0000_0012, q);
      wb(1'b0, timer_capture_pkg::IDX_PC1_LOW, 8'h00);
      chk_val("cap1 low", {24'h00_0000, wide[7:0]}, q);
    end
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    wb(1'b0, timer_capture_pkg::IDX_CONTROL, 8'h00);
    chk_val("control after reset", 32'h0000_0000, q);
    complete_run();
  end
endmodule

bind dual_timer_capture_unit timer_capture_checker u_chk (.ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o),
  .lower_period_tick_o(lower_period_tick_o), .upper_period_tick_o(upper_period_tick_o),
  .lower_timer_o(lower_timer_o), .upper_timer_o(upper_timer_o));
